// file: hw/rpe_pkg.sv
// Shared constants and types of the receive PCM event reporter.
// Assumes one 40 MHz clock domain and a synchronous active high reset.
package rpe_pkg;

   // ----------------------------------------
   // Field widths
   // ----------------------------------------
   localparam int TS_W = 32;    // Remote and local timestamps
   localparam int LEAD_W = 16;  // Leads and buffer sizes, in frames
   localparam int BYTES_W = 11; // Payload byte count
   localparam int NCH_W = 8;    // Channels per packet
   localparam int BPS_W = 4;    // Bits per sample
   localparam int SMP_W = 14;   // Frames in one packet
   localparam int ADDR_W = 24;  // Channel structure address
   localparam int FLAG_W = 13;  // Report flag vector

   // ----------------------------------------
   // Report flag positions
   // ----------------------------------------
   localparam int F_LATE = 0;       // late_arrival_flag
   localparam int F_BEYOND = 1;     // late_beyond_window_flag
   localparam int F_OVER = 2;       // overrun_flag
   localparam int F_COLD = 3;       // channel_cold_start_flag
   localparam int F_COMMON = 4;     // common_first_packet_flag
   localparam int F_RESTART = 5;    // monitor_restart_flag
   localparam int F_DRIFT = 6;      // drift_total_cleared_flag
   localparam int F_DROP = 7;       // dropped_samples_flag
   localparam int F_MISMATCH = 8;   // payload_width_mismatch_flag
   localparam int F_OVERSIZE = 9;   // oversize_payload_flag
   localparam int F_EXCESS = 10;    // sample_count_excess_flag
   localparam int F_EMPTY = 11;     // empty_payload_flag
   localparam int F_EXTREME = 12;   // extreme_delay_flag

   // ----------------------------------------
   // Limits and reset values
   // ----------------------------------------
   localparam logic [SMP_W-1:0] MAX_FRAMES = 14'h07FF;  // Largest legal frame count
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;         // Byte to bit factor
   localparam logic [TS_W-1:0] SLIP_RST = 32'h0000_0000; // Slip total after reset

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic {
      ST_IDLE = 1'b0, // Waiting for a packet
      ST_EVAL = 1'b1  // Channel entry read back, deciding
   } rpe_state_e;

   // Per-channel context kept in memory
   typedef struct packed {
      logic init;                 // First packet seen
      logic [TS_W-1:0] delta;     // Remote minus local minus lead
      logic [TS_W-1:0] last_ts;   // Remote timestamp of last packet
      logic [SMP_W-1:0] last_smp; // Frames in last packet
   } rpe_entry_s;

   localparam int ENTRY_W = $bits(rpe_entry_s);

endpackage

// file: hw/rpe_ctx_mem.sv
// Per-channel context memory of the event reporter.
// Assumes one clock; read data are registered, one read port and one write port.
`timescale 1ns/1ps
module rpe_ctx_mem #(
   parameter int W = 16,      // Word width
   parameter int AW = 10      // Address width
) (
   input wire logic clk,
   input wire logic ce,
   input wire logic rd_en,
   input wire logic [AW-1:0] rd_addr,
   output logic [W-1:0] rd_data,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [W-1:0] wr_data
);

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   logic [W-1:0] mem [0:(1<<AW)-1]; // One word per channel

   // Refuse sizes the storage cannot serve, at elaboration
   if (W < 1 || AW < 1 || AW > 12) begin : g_size_chk
      $error("rpe_ctx_mem: unsupported size");
   end

   // Write and registered read, frozen with the clock enable
   always_ff @(posedge clk) begin
      if (ce) begin
         if (wr_en) begin
            mem[wr_addr] <= wr_data;
         end
         if (rd_en) begin
            rd_data <= mem[rd_addr];
         end
      end
   end

endmodule

// file: hw/rpe_core.sv
// Receive PCM event reporter: checks each packet against its channel
// context, repositions the write pointer and emits one report per flagged packet.
// Assumes config ports hold steady from packet accept to report, and that
// software clears each channel context through chan_init before use.
`timescale 1ns/1ps

// Functional notes
// - Flag packet whose first sample is late
// - Flag late even with packetization delay added
// - Flag last sample beyond max used samples
// - Flag first packet of a channel
// - Flag first packet of common structure
// - Flag completed monitoring restart
// - Flag reset of accumulated slip offset
// - Dropped flag exactly when lost count nonzero
// - Flag and discard indivisible payload length
// - Flag samples above max expected payload
// - Flag sample count above 2047 frames
// - Flag packet with zero frames
// - Flag extreme delay from extended monitor
// - Report carries channel structure address
// - Lost count from consecutive remote timestamps
// - Report carries packet remote timestamp
// - Report carries local bus timestamp
// - Restart request consumed and cleared by hardware
// - Underrun moves pointer to underrun lead
// - Overrun without underrun moves pointer to overrun lead
// - First packet uses initial lead
module rpe_core #(
   parameter int CH_W = 10 // Channel index width
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic pkt_valid,
   output logic pkt_ready,
   input wire logic [CH_W-1:0] pkt_chan,
   input wire logic [rpe_pkg::ADDR_W-1:0] pkt_struct_addr,
   input wire logic [rpe_pkg::TS_W-1:0] pkt_remote_ts,
   input wire logic [rpe_pkg::BYTES_W-1:0] pkt_bytes,
   input wire logic [rpe_pkg::NCH_W-1:0] pkt_num_chan,
   input wire logic [rpe_pkg::BPS_W-1:0] pkt_bits_per_smp,
   input wire logic [rpe_pkg::TS_W-1:0] local_ts,
   input wire logic [rpe_pkg::LEAD_W-1:0] cfg_max_used,
   input wire logic [rpe_pkg::LEAD_W-1:0] cfg_max_expected,
   input wire logic [rpe_pkg::LEAD_W-1:0] cfg_init_lead,
   input wire logic [rpe_pkg::LEAD_W-1:0] cfg_underrun_lead,
   input wire logic [rpe_pkg::LEAD_W-1:0] cfg_overrun_lead,
   input wire logic restart_req,
   output logic restart_clr,
   input wire logic slip_reset_req,
   output logic slip_clr,
   input wire logic extreme_delay_in,
   input wire logic chan_init_valid,
   input wire logic [CH_W-1:0] chan_init_idx,
   output logic rpt_valid,
   output logic [rpe_pkg::FLAG_W-1:0] rpt_flags,
   output logic [rpe_pkg::ADDR_W-1:0] rpt_struct_addr,
   output logic [rpe_pkg::TS_W-1:0] rpt_lost,
   output logic [rpe_pkg::TS_W-1:0] rpt_remote_ts,
   output logic [rpe_pkg::TS_W-1:0] rpt_local_ts,
   output logic wp_valid,
   output logic [rpe_pkg::TS_W-1:0] wp_ptr,
   output logic [rpe_pkg::TS_W-1:0] slip_total
);

   // ----------------------------------------
   // State record
   // ----------------------------------------
   typedef struct packed {
      rpe_pkg::rpe_state_e st;                   // Sequencer state
      logic [CH_W-1:0] chan;                     // Channel in flight
      logic [rpe_pkg::ADDR_W-1:0] addr;          // Structure address in flight
      logic [rpe_pkg::TS_W-1:0] remote;          // Remote timestamp in flight
      logic [rpe_pkg::TS_W-1:0] local_t;         // Local timestamp at accept
      logic [rpe_pkg::BYTES_W-1:0] bytes;        // Payload bytes in flight
      logic [rpe_pkg::NCH_W-1:0] nch;            // Channels per packet
      logic [rpe_pkg::BPS_W-1:0] bps;            // Bits per sample
      logic common_seen;                         // Common structure started
      logic [rpe_pkg::TS_W-1:0] slip_tot;        // Accumulated slip offset
      logic rpt_v;                               // Report strobe
      logic [rpe_pkg::FLAG_W-1:0] flags;         // Report flags
      logic [rpe_pkg::ADDR_W-1:0] r_addr;        // Report address
      logic [rpe_pkg::TS_W-1:0] r_lost;          // Report lost count
      logic [rpe_pkg::TS_W-1:0] r_remote;        // Report remote time
      logic [rpe_pkg::TS_W-1:0] r_local;         // Report local time
      logic wp_v;                                // Pointer update strobe
      logic [rpe_pkg::TS_W-1:0] wp;              // New write pointer
      logic rst_clr;                             // Restart request clear
      logic slp_clr;                             // Slip reset request clear
   } rpe_core_s;

   rpe_core_s s_q; // Registered state
   rpe_core_s s_d; // Next state

   // ----------------------------------------
   // Context memory link
   // ----------------------------------------
   rpe_pkg::rpe_entry_s rd_ent;  // Entry read for the packet
   rpe_pkg::rpe_entry_s wr_ent;  // Entry written back
   logic mem_rd;                 // Read strobe
   logic mem_wr;                 // Write strobe
   logic [CH_W-1:0] mem_waddr;   // Write address
   logic take;                   // Packet accepted this cycle
   logic init_take;              // Channel clear accepted this cycle

   // Refuse channel widths the context memory cannot hold, at elaboration
   if (CH_W < 1 || CH_W > 12) begin : g_chan_chk
      $error("rpe_core: CH_W out of range");
   end

   rpe_ctx_mem #(
      .W(rpe_pkg::ENTRY_W),
      .AW(CH_W)
   ) u_ctx (
      .clk(clk),
      .ce(ce),
      .rd_en(mem_rd),
      .rd_addr(pkt_chan),
      .rd_data(rd_ent),
      .wr_en(mem_wr),
      .wr_addr(mem_waddr),
      .wr_data(wr_ent)
   );

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Frames per packet and a flag for a length that does not divide
   function automatic logic [rpe_pkg::SMP_W:0] frames_of(
      input logic [rpe_pkg::BYTES_W-1:0] b,
      input logic [rpe_pkg::NCH_W-1:0] n,
      input logic [rpe_pkg::BPS_W-1:0] p
   );
      logic [14:0] bits;
      logic [11:0] per;
      logic [14:0] q;
      bits = 15'(b) * 15'(rpe_pkg::BITS_PER_BYTE);
      per = 12'(n) * 12'(p);
      q = 15'h0000;
      if (per == 12'h000) begin
         frames_of = {1'b1, {rpe_pkg::SMP_W{1'b0}}};
      end else begin
         q = bits / 15'(per);
         frames_of = {(bits % 15'(per)) != 15'h0000, q[rpe_pkg::SMP_W-1:0]};
      end
   endfunction

   // Handshake terms
   assign init_take = (s_q.st == rpe_pkg::ST_IDLE) && chan_init_valid;
   assign pkt_ready = (s_q.st == rpe_pkg::ST_IDLE) && !chan_init_valid;
   assign take = pkt_valid && pkt_ready;
   assign mem_rd = take;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic [rpe_pkg::SMP_W:0] fr;
      logic [rpe_pkg::SMP_W-1:0] smp;
      logic bad;
      logic first;
      logic signed [rpe_pkg::TS_W-1:0] lead;
      logic signed [rpe_pkg::TS_W-1:0] new_lead;
      logic signed [rpe_pkg::TS_W-1:0] gap;
      logic [rpe_pkg::TS_W-1:0] slip_base;
      logic late;
      logic beyond;
      logic over;
      logic [rpe_pkg::FLAG_W-1:0] f;
      fr = '0;
      smp = '0;
      bad = 1'b0;
      first = 1'b0;
      lead = '0;
      new_lead = '0;
      gap = '0;
      slip_base = '0;
      late = 1'b0;
      beyond = 1'b0;
      over = 1'b0;
      f = '0;
      s_d = s_q;
      // Strobes last one cycle
      s_d.rpt_v = 1'b0;
      s_d.wp_v = 1'b0;
      s_d.rst_clr = 1'b0;
      s_d.slp_clr = 1'b0;
      mem_wr = 1'b0;
      mem_waddr = chan_init_idx;
      wr_ent = '0;
      case (s_q.st)
         rpe_pkg::ST_IDLE: begin
            // Channel clear wins over a packet
            if (init_take) begin
               mem_wr = 1'b1;
            end else if (take) begin
               s_d.st = rpe_pkg::ST_EVAL;
               s_d.chan = pkt_chan;
               s_d.addr = pkt_struct_addr;
               s_d.remote = pkt_remote_ts;
               s_d.local_t = local_ts;
               s_d.bytes = pkt_bytes;
               s_d.nch = pkt_num_chan;
               s_d.bps = pkt_bits_per_smp;
            end
         end
         rpe_pkg::ST_EVAL: begin
            s_d.st = rpe_pkg::ST_IDLE;
            fr = frames_of(s_q.bytes, s_q.nch, s_q.bps);
            bad = fr[rpe_pkg::SMP_W];
            smp = fr[rpe_pkg::SMP_W-1:0];
            first = !rd_ent.init;
            // Lead of the first sample against the read pointer
            lead = signed'(s_q.remote - rd_ent.delta - s_q.local_t);
            late = !first && (lead < 0);
            beyond = !first && (lead < signed'(32'(cfg_max_expected)) - signed'(32'(smp)));
            over = !first && (lead + signed'(32'(smp)) - 1 > signed'(32'(cfg_max_used)));
            // Gap between expected and received remote time
            gap = signed'(s_q.remote - rd_ent.last_ts - 32'(rd_ent.last_smp));
            // Choose the new lead, first packet before slips
            if (first) begin
               new_lead = signed'(32'(cfg_init_lead));
            end else if (beyond) begin
               new_lead = signed'(32'(cfg_underrun_lead));
            end else if (over) begin
               new_lead = signed'(32'(cfg_overrun_lead));
            end else begin
               new_lead = lead;
            end
            f[rpe_pkg::F_MISMATCH] = bad;
            f[rpe_pkg::F_EMPTY] = !bad && (smp == '0);
            f[rpe_pkg::F_EXTREME] = extreme_delay_in;
            if (!bad && smp != '0) begin
               f[rpe_pkg::F_LATE] = late;
               f[rpe_pkg::F_BEYOND] = beyond;
               f[rpe_pkg::F_OVER] = over;
               f[rpe_pkg::F_COLD] = first;
               f[rpe_pkg::F_COMMON] = !s_q.common_seen;
               f[rpe_pkg::F_RESTART] = restart_req;
               f[rpe_pkg::F_DRIFT] = slip_reset_req;
               f[rpe_pkg::F_OVERSIZE] = cfg_max_expected != '0 && 16'(smp) > cfg_max_expected;
               f[rpe_pkg::F_EXCESS] = smp > rpe_pkg::MAX_FRAMES;
               if (!first && gap > 0) begin
                  s_d.r_lost = 32'(gap);
               end else begin
                  s_d.r_lost = '0;
               end
               f[rpe_pkg::F_DROP] = !first && gap > 0;
               s_d.common_seen = 1'b1;
               // Reset of the total wins, then this packet's slip adds in
               slip_base = slip_reset_req ? rpe_pkg::SLIP_RST : s_q.slip_tot;
               s_d.slip_tot = first ? slip_base : slip_base + 32'(new_lead - lead);
               s_d.rst_clr = restart_req;
               s_d.slp_clr = slip_reset_req;
               // Write pointer and context update
               s_d.wp_v = 1'b1;
               s_d.wp = s_q.local_t + 32'(new_lead);
               mem_wr = 1'b1;
               mem_waddr = s_q.chan;
               wr_ent.init = 1'b1;
               wr_ent.delta = s_q.remote - s_q.local_t - 32'(new_lead);
               wr_ent.last_ts = s_q.remote;
               wr_ent.last_smp = smp;
            end else begin
               s_d.r_lost = '0;
            end
            // Report only when something is flagged
            s_d.rpt_v = f != '0;
            s_d.flags = f;
            s_d.r_addr = s_q.addr;
            s_d.r_remote = s_q.remote;
            s_d.r_local = s_q.local_t;
         end
         default: begin
            s_d.st = rpe_pkg::ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         s_q <= '0;
         s_q.st <= rpe_pkg::ST_IDLE;
         s_q.slip_tot <= rpe_pkg::SLIP_RST;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign rpt_valid = s_q.rpt_v;
   assign rpt_flags = s_q.flags;
   assign rpt_struct_addr = s_q.r_addr;
   assign rpt_lost = s_q.r_lost;
   assign rpt_remote_ts = s_q.r_remote;
   assign rpt_local_ts = s_q.r_local;
   assign wp_valid = s_q.wp_v;
   assign wp_ptr = s_q.wp;
   assign restart_clr = s_q.rst_clr;
   assign slip_clr = s_q.slp_clr;
   assign slip_total = s_q.slip_tot;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence s_accept;
      take && ce;
   endsequence

   sequence s_decide;
      s_q.st == rpe_pkg::ST_EVAL && ce;
   endsequence

   pkt_to_eval_a: assert property (s_accept |=> s_q.st == rpe_pkg::ST_EVAL)
      else $error("accepted packet not evaluated");
   eval_report_a: assert property (s_accept ##1 s_decide |=>
      rpt_valid == (rpt_flags != '0) && rpt_remote_ts == $past(pkt_remote_ts, 2))
      else $error("report strobe or remote time wrong");
   report_flags_a: assert property (rpt_valid |-> rpt_flags != '0)
      else $error("report without any flag");
   lost_flag_a: assert property (rpt_valid |-> rpt_flags[rpe_pkg::F_DROP] == (rpt_lost != '0))
      else $error("dropped flag disagrees with count");
   mismatch_drop_a: assert property (rpt_valid && rpt_flags[rpe_pkg::F_MISMATCH] |-> !wp_valid)
      else $error("bad length packet moved pointer");
   restart_clr_a: assert property (restart_clr |-> rpt_valid && rpt_flags[rpe_pkg::F_RESTART])
      else $error("restart cleared without report");
   underrun_lead_a: assert property (wp_valid && rpt_flags[rpe_pkg::F_BEYOND] |->
      wp_ptr - rpt_local_ts == 32'(cfg_underrun_lead))
      else $error("underrun lead not applied");
   overrun_lead_a: assert property (wp_valid && rpt_flags[rpe_pkg::F_OVER] && !rpt_flags[rpe_pkg::F_BEYOND] |->
      wp_ptr - rpt_local_ts == 32'(cfg_overrun_lead))
      else $error("overrun lead not applied");
   cold_lead_a: assert property (wp_valid && rpt_flags[rpe_pkg::F_COLD] |->
      wp_ptr - rpt_local_ts == 32'(cfg_init_lead) && !rpt_flags[rpe_pkg::F_LATE])
      else $error("initial lead not applied");
   // Without a slip on the same packet the cleared total must read zero
   slip_reset_a: assert property (slip_clr |-> rpt_valid && rpt_flags[rpe_pkg::F_DRIFT] &&
      (rpt_flags[rpe_pkg::F_BEYOND] || rpt_flags[rpe_pkg::F_OVER] || slip_total == '0))
      else $error("slip reset not reported or total not cleared");

endmodule

// file: test/rpe_core_tb_top.sv
// Self-checking bench of the receive PCM event reporter core.
// Assumes rpe_core and rpe_pkg are compiled first; the bench drives every port.
`timescale 1ns/1ps
module rpe_core_tb_top;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic clk, srst, ce, pkt_valid, pkt_ready, restart_req, restart_clr;
   logic slip_reset_req, slip_clr, extreme_delay_in, chan_init_valid, rpt_valid, wp_valid;
   logic [9:0] pkt_chan, chan_init_idx;
   logic [23:0] pkt_struct_addr, rpt_struct_addr;
   logic [31:0] pkt_remote_ts, local_ts, rpt_lost, rpt_remote_ts, rpt_local_ts, wp_ptr, slip_total;
   logic [10:0] pkt_bytes;
   logic [7:0] pkt_num_chan;
   logic [3:0] pkt_bits_per_smp;
   logic [15:0] cfg_max_used, cfg_max_expected, cfg_init_lead, cfg_underrun_lead, cfg_overrun_lead;
   logic [12:0] rpt_flags;
   int miscompares, comparisons, cycles;

   rpe_core #(.CH_W(10)) i_rpe_core (.clk(clk), .srst(srst), .ce(ce), .pkt_valid(pkt_valid),
      .pkt_ready(pkt_ready), .pkt_chan(pkt_chan), .pkt_struct_addr(pkt_struct_addr),
      .pkt_remote_ts(pkt_remote_ts), .pkt_bytes(pkt_bytes), .pkt_num_chan(pkt_num_chan),
      .pkt_bits_per_smp(pkt_bits_per_smp), .local_ts(local_ts), .cfg_max_used(cfg_max_used),
      .cfg_max_expected(cfg_max_expected), .cfg_init_lead(cfg_init_lead),
      .cfg_underrun_lead(cfg_underrun_lead), .cfg_overrun_lead(cfg_overrun_lead),
      .restart_req(restart_req), .restart_clr(restart_clr), .slip_reset_req(slip_reset_req),
      .slip_clr(slip_clr), .extreme_delay_in(extreme_delay_in), .chan_init_valid(chan_init_valid),
      .chan_init_idx(chan_init_idx), .rpt_valid(rpt_valid), .rpt_flags(rpt_flags),
      .rpt_struct_addr(rpt_struct_addr), .rpt_lost(rpt_lost), .rpt_remote_ts(rpt_remote_ts),
      .rpt_local_ts(rpt_local_ts), .wp_valid(wp_valid), .wp_ptr(wp_ptr), .slip_total(slip_total));

   // ----------------------------------------
   // Clock and hang guard
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Cut a hang short after far more cycles than the run needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         conclude();
      end
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task conclude();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Compare one value, zero extended to 32 bits
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   // Clear one channel context while idle
   task clear_chan(input logic [9:0] ch);
      @(negedge clk);
      chan_init_valid = 1'b1;
      chan_init_idx = ch;
      @(negedge clk);
      chan_init_valid = 1'b0;
   endtask
   // Offer one packet, wait for accept and evaluate, stop in the result cycle
   task send(input logic [9:0] ch, input logic [31:0] rts, input logic [10:0] nb, input logic [7:0] nc,
             input logic [3:0] bp, input logic [31:0] lts);
      int n;
      n = 0;
      @(negedge clk);
      pkt_chan = ch;
      pkt_struct_addr = {14'h0, ch} + 24'h01_0000;
      pkt_remote_ts = rts;
      pkt_bytes = nb;
      pkt_num_chan = nc;
      pkt_bits_per_smp = bp;
      local_ts = lts;
      pkt_valid = 1'b1;
      while (pkt_ready !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      @(posedge clk);
      @(negedge clk);
      pkt_valid = 1'b0;
      chk("pkt_ready", 32'h0, {31'h0, pkt_ready});
      @(posedge clk);
      @(negedge clk);
   endtask
   // Judge the report and pointer strobes of the result cycle
   task rpt(input logic [12:0] fl, input logic [31:0] lost, input logic wpv, input logic [31:0] wp);
      chk("rpt_valid", {31'h0, fl != 13'h0000}, {31'h0, rpt_valid});
      if (fl != 13'h0000) begin
         chk("rpt_flags", {19'h0, fl}, {19'h0, rpt_flags});
         chk("rpt_lost", lost, rpt_lost);
         chk("rpt_remote_ts", pkt_remote_ts, rpt_remote_ts);
         chk("rpt_local_ts", local_ts, rpt_local_ts);
         chk("rpt_struct_addr", {8'h0, pkt_struct_addr}, {8'h0, rpt_struct_addr});
      end
      chk("wp_valid", {31'h0, wpv}, {31'h0, wp_valid});
      if (wpv)
         chk("wp_ptr", wp, wp_ptr);
   endtask

   // ----------------------------------------
   // Scenarios, on 40 frame packets except mismatch, empty, oversize, excess and the second rerun packet
   // ----------------------------------------
   task t_cold();
      clear_chan(10'h001);
      clear_chan(10'h002);
      send(10'h001, 32'h0000_03E8, 11'h028, 8'h01, 4'h8, 32'h0000_01F4);
      rpt(13'h0018, 32'h0, 1'b1, 32'h0000_01FE);
      send(10'h002, 32'h0000_1388, 11'h028, 8'h01, 4'h8, 32'h0000_0208);
      rpt(13'h0008, 32'h0, 1'b1, 32'h0000_0212);
   endtask
   task t_clean();
      send(10'h001, 32'h0000_0410, 11'h028, 8'h01, 4'h8, 32'h0000_021C);
      rpt(13'h0000, 32'h0, 1'b1, 32'h0000_0226);
   endtask
   task t_lost();
      send(10'h001, 32'h0000_044C, 11'h028, 8'h01, 4'h8, 32'h0000_0258);
      rpt(13'h0080, 32'h0000_0014, 1'b1, 32'h0000_0262);
      // Clock enable low holds the strobes and all state
      ce = 1'b0;
      repeat (3) @(negedge clk);
      chk("rpt_valid", 32'h1, {31'h0, rpt_valid});
      chk("wp_ptr", 32'h0000_0262, wp_ptr);
      ce = 1'b1;
      @(negedge clk);
      chk("rpt_valid", 32'h0, {31'h0, rpt_valid});
   endtask
   task t_under();
      send(10'h001, 32'h0000_0474, 11'h028, 8'h01, 4'h8, 32'h0000_02BC);
      rpt(13'h0003, 32'h0, 1'b1, 32'h0000_02C4);
      chk("slip_total", 32'h0000_003A, slip_total);
   endtask
   task t_over();
      cfg_max_used = 16'h003C;
      send(10'h001, 32'h0000_049C, 11'h028, 8'h01, 4'h8, 32'h0000_02C6);
      rpt(13'h0004, 32'h0, 1'b1, 32'h0000_02DA);
      chk("slip_total", 32'h0000_0028, slip_total);
   endtask
   task t_ctrl();
      restart_req = 1'b1;
      slip_reset_req = 1'b1;
      extreme_delay_in = 1'b1;
      send(10'h001, 32'h0000_04C4, 11'h028, 8'h01, 4'h8, 32'h0000_02EE);
      rpt(13'h1060, 32'h0, 1'b1, 32'h0000_0302);
      chk("restart_clr", 32'h1, {31'h0, restart_clr});
      chk("slip_clr", 32'h1, {31'h0, slip_clr});
      chk("slip_total", 32'h0, slip_total);
      restart_req = 1'b0;
      slip_reset_req = 1'b0;
      extreme_delay_in = 1'b0;
      @(negedge clk);
      chk("restart_clr", 32'h0, {31'h0, restart_clr});
   endtask
   task t_mismatch();
      send(10'h001, 32'h0000_04EC, 11'h028, 8'h03, 4'h8, 32'h0000_0316);
      rpt(13'h0100, 32'h0, 1'b0, 32'h0);
   endtask
   task t_empty();
      send(10'h001, 32'h0000_0514, 11'h000, 8'h01, 4'h8, 32'h0000_0316);
      rpt(13'h0800, 32'h0, 1'b0, 32'h0);
   endtask
   task t_oversize();
      cfg_max_used = 16'h00C8;
      send(10'h001, 32'h0000_04EC, 11'h030, 8'h01, 4'h8, 32'h0000_0316);
      rpt(13'h0200, 32'h0, 1'b1, 32'h0000_032A);
   endtask
   task t_excess();
      send(10'h001, 32'h0000_051C, 11'h7F8, 8'h01, 4'h1, 32'h0000_0346);
      chk("rpt_valid", 32'h1, {31'h0, rpt_valid});
      chk("rpt_flags", 32'h0600, {19'h0, rpt_flags & 13'h0600});
   endtask
   // Mid-run reset restarts the common structure; zero max expected turns oversize off
   task t_rerun();
      srst = 1'b1;
      repeat (2) @(negedge clk);
      srst = 1'b0;
      chk("rpt_valid", 32'h0, {31'h0, rpt_valid});
      send(10'h002, 32'h0000_13B0, 11'h028, 8'h01, 4'h8, 32'h0000_0230);
      rpt(13'h0010, 32'h0, 1'b1, 32'h0000_023A);
      cfg_max_expected = 16'h0000;
      send(10'h002, 32'h0000_13D8, 11'h030, 8'h01, 4'h8, 32'h0000_0258);
      rpt(13'h0000, 32'h0, 1'b1, 32'h0000_0262);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      srst = 1'b1;
      ce = 1'b1;
      pkt_valid = 1'b0;
      pkt_chan = 10'h000;
      pkt_struct_addr = 24'h00_0000;
      pkt_remote_ts = 32'h0;
      pkt_bytes = 11'h000;
      pkt_num_chan = 8'h01;
      pkt_bits_per_smp = 4'h8;
      local_ts = 32'h0;
      cfg_max_used = 16'h00C8;
      cfg_max_expected = 16'h0028;
      cfg_init_lead = 16'h000A;
      cfg_underrun_lead = 16'h0008;
      cfg_overrun_lead = 16'h0014;
      restart_req = 1'b0;
      slip_reset_req = 1'b0;
      extreme_delay_in = 1'b0;
      chan_init_valid = 1'b0;
      chan_init_idx = 10'h000;
      repeat (10) @(negedge clk);
      srst = 1'b0;
      t_cold();
      t_clean();
      t_lost();
      t_under();
      t_over();
      t_ctrl();
      t_mismatch();
      t_empty();
      t_oversize();
      t_excess();
      t_rerun();
      conclude();
   end
endmodule
